/* pct_pkg.sv */
// Purpose: Shared constants and types for the pipeline cycle-timing block
// Assumes: One 100 MHz clock, synchronous active-low reset
// Notes:   All stage and access cycle figures live here
`default_nettype none
package pct_pkg;
  localparam int CNT_W = 6;
  localparam int TAG_W = 8;
  localparam int NUM_TIMED = 3;
  localparam int TIMED_FETCH = 0;
  localparam int TIMED_EXEC = 1;
  localparam int TIMED_ACCESS = 2;

  localparam logic [5:0] EXEC_BASE = 6'h01;
  localparam logic [5:0] EXEC_PRODUCT = 6'h03;
  localparam logic [5:0] EXEC_QUOTIENT = 6'h25;

  localparam logic [5:0] CYC_QUEUE = 6'h01;
  localparam logic [5:0] CYC_INT_RD = 6'h01;
  localparam logic [5:0] CYC_PER_RD_BH = 6'h02;
  localparam logic [5:0] CYC_PER_RD_W = 6'h04;
  localparam logic [5:0] CYC_EXT_RD_BH = 6'h05;
  localparam logic [5:0] CYC_EXT_RD_W = 6'h09;
  localparam logic [5:0] CYC_EXT_FETCH = 6'h08;
  localparam logic [5:0] CYC_INT_WR = 6'h01;
  localparam logic [5:0] CYC_PER_WR_BH = 6'h02;
  localparam logic [5:0] CYC_PER_WR_W = 6'h04;
  localparam logic [5:0] CYC_EXT_WR_BH = 6'h04;
  localparam logic [5:0] CYC_EXT_WR_W = 6'h08;

  typedef enum logic [2:0] {CLS_LOAD, CLS_STORE, CLS_PRODUCT, CLS_QUOTIENT, CLS_MODULO, CLS_OTHER} pct_cls_t;
  typedef enum logic [1:0] {RGN_QUEUE, RGN_INTERNAL, RGN_PERIPH, RGN_EXTERNAL} pct_rgn_t;
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} pct_size_t;
  typedef enum logic [1:0] {ACC_FETCH, ACC_READ, ACC_WRITE} pct_acc_t;

  typedef struct packed {
    logic             vld;
    pct_cls_t         cls;
    logic             brn;
    pct_rgn_t         mrgn;
    pct_size_t        msize;
    pct_rgn_t         fsrc;
    logic [TAG_W-1:0] tag;
  } pct_stage_t;
endpackage
`default_nettype wire

/* pct_access_lut.sv */
// Purpose: Minimum cycle count for one fetch, read or write
// Assumes: External figures already hold the single wait cycle
// Notes:   Pure combinational table
`default_nettype none
module pct_access_lut (
  input  wire pct_pkg::pct_acc_t  kind,   // Fetch, read or write
  input  wire pct_pkg::pct_rgn_t  rgn,    // Target region
  input  wire pct_pkg::pct_size_t size,   // Access width
  output logic [5:0]              cycles  // Minimum occupancy
);
  always_comb begin
    cycles = pct_pkg::CYC_INT_RD;
    case (rgn)
      pct_pkg::RGN_QUEUE:    cycles = pct_pkg::CYC_QUEUE;
      pct_pkg::RGN_INTERNAL: cycles = (kind == pct_pkg::ACC_WRITE) ? pct_pkg::CYC_INT_WR
                                                                     : pct_pkg::CYC_INT_RD;
      pct_pkg::RGN_PERIPH: begin
        if (kind == pct_pkg::ACC_WRITE) begin
          cycles = (size == pct_pkg::SZ_WORD) ? pct_pkg::CYC_PER_WR_W : pct_pkg::CYC_PER_WR_BH;
        end else begin
          cycles = (size == pct_pkg::SZ_WORD) ? pct_pkg::CYC_PER_RD_W : pct_pkg::CYC_PER_RD_BH;
        end
      end
      pct_pkg::RGN_EXTERNAL: begin
        // One wait cycle is folded into every figure here
        if (kind == pct_pkg::ACC_FETCH) begin
          cycles = pct_pkg::CYC_EXT_FETCH;
        end else if (kind == pct_pkg::ACC_WRITE) begin
          cycles = (size == pct_pkg::SZ_WORD) ? pct_pkg::CYC_EXT_WR_W : pct_pkg::CYC_EXT_WR_BH;
        end else begin
          cycles = (size == pct_pkg::SZ_WORD) ? pct_pkg::CYC_EXT_RD_W : pct_pkg::CYC_EXT_RD_BH;
        end
      end
      default: cycles = pct_pkg::CYC_INT_RD;
    endcase
  end
endmodule
`default_nettype wire

/* pct_occ_timer.sv */
// Purpose: Counts how long one stage has held its instruction
// Assumes: leave is asserted only in a cycle where done is high
// Notes:   Count saturates so a long stall cannot wrap it
`default_nettype none
module pct_occ_timer #(
  parameter int CNT_W = pct_pkg::CNT_W
) (
  input  wire logic             ref_clk,  // System clock
  input  wire logic             rst_n,    // Sync reset, active low
  input  wire logic             ce,       // Clock enable
  input  wire logic             occupied, // Stage holds an instruction
  input  wire logic             leave,    // Occupant moves on this cycle
  input  wire logic [CNT_W-1:0] target,   // Minimum cycles in stage
  input  wire logic             ready,    // Far side can finish now
  output logic                  done      // Occupancy satisfied
);
  if (CNT_W < 6) begin : g_chk
    $error("CNT_W too small for longest stage");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } pct_tmr_t;

  pct_tmr_t st;
  pct_tmr_t next_st;
  logic [CNT_W:0] elapsed;

  // Bus may hold ready low past the minimum
  assign elapsed = {1'b0, st.cnt} + {{CNT_W{1'b0}}, 1'b1};
  assign done = occupied && (elapsed >= {1'b0, target}) && ready;

  always_comb begin
    next_st = st;
    if (!occupied || leave) begin
      next_st.cnt = '0;
    end else if (st.cnt != {CNT_W{1'b1}}) begin
      next_st.cnt = elapsed[CNT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

/* pct_pipeline.sv */
// Purpose: Five-stage in-order pipeline occupancy and advance control
// Assumes: Instructions arrive decoded enough to know class and access
// Notes:   Models timing only; no data path is carried
`default_nettype none
module pct_pipeline #(
  parameter int TAG_W = pct_pkg::TAG_W
) (
  input  wire logic               ref_clk,     // System clock
  input  wire logic               rst_n,       // Sync reset, active low
  input  wire logic               ce,          // Clock enable
  input  wire logic               in_valid,    // Instruction offered
  output logic                    in_ready,    // Fetch stage accepts
  input  wire pct_pkg::pct_cls_t  in_cls,      // Instruction class
  input  wire logic               in_branch,   // Instruction is a branch
  input  wire pct_pkg::pct_rgn_t  in_fsrc,     // Where it is fetched from
  input  wire pct_pkg::pct_rgn_t  in_mrgn,     // Data access region
  input  wire pct_pkg::pct_size_t in_msize,    // Data access width
  input  wire logic [TAG_W-1:0]   in_tag,      // Caller's tag
  output logic                    fetch_req,   // Fetch on the bus
  output pct_pkg::pct_rgn_t       fetch_rgn,   // Fetch region
  output logic [TAG_W-1:0]        fetch_tag,   // Tag being fetched
  input  wire logic               fetch_rdy,   // Fetch may complete
  output logic                    mem_req,     // Data access active
  output logic                    mem_we,      // Access is a write
  output pct_pkg::pct_rgn_t       mem_rgn,     // Access region
  output pct_pkg::pct_size_t      mem_size,    // Access width
  output logic [TAG_W-1:0]        mem_tag,     // Tag of the access
  input  wire logic               mem_rdy,     // Access may complete
  output logic                    wbuf_post,   // Store posted this cycle
  input  wire logic               wbuf_ready,  // Write buffer has room
  output logic                    retire,      // Write-back this cycle
  output logic [TAG_W-1:0]        retire_tag,  // Tag written back
  output logic [4:0]              stage_busy,  // Occupancy per stage
  output logic                    stalled,     // Some stage is held
  output logic [15:0]             stall_count  // Held cycles, saturating
);
  if (TAG_W != pct_pkg::TAG_W) begin : g_chk
    $error("TAG_W must match the stage record");
  end

  typedef struct packed {
    pct_pkg::pct_stage_t fetch_stage;
    pct_pkg::pct_stage_t decode_stage;
    pct_pkg::pct_stage_t exec_stage;
    pct_pkg::pct_stage_t access_stage;
    pct_pkg::pct_stage_t writeback_stage;
    logic [15:0]         stalls;
  } pct_core_t;

  pct_core_t st;
  pct_core_t next_st;

  logic [pct_pkg::NUM_TIMED-1:0] t_occ;
  logic [pct_pkg::NUM_TIMED-1:0] t_leave;
  logic [pct_pkg::NUM_TIMED-1:0] t_rdy;
  logic [pct_pkg::NUM_TIMED-1:0] t_done;
  logic [5:0]                    t_target [pct_pkg::NUM_TIMED];

  logic [5:0]        fetch_cycles;
  logic [5:0]        access_cycles;
  logic [5:0]        exec_cycles;
  pct_pkg::pct_acc_t access_kind;

  logic branch_pending;
  logic ex_needs_access;
  logic acc_is_store;
  logic acc_to_wb;
  logic acc_post;
  logic acc_leave;
  logic ex_to_acc;
  logic ex_to_wb;
  logic ex_leave;
  logic dec_to_ex;
  logic fetch_to_dec;
  logic fetch_take;
  logic any_hold;

  // Execute occupancy per class
  always_comb begin
    case (st.exec_stage.cls)
      pct_pkg::CLS_PRODUCT:  exec_cycles = pct_pkg::EXEC_PRODUCT;
      pct_pkg::CLS_QUOTIENT: exec_cycles = pct_pkg::EXEC_QUOTIENT;
      pct_pkg::CLS_MODULO:   exec_cycles = pct_pkg::EXEC_QUOTIENT;
      pct_pkg::CLS_LOAD:     exec_cycles = pct_pkg::EXEC_BASE;
      default:               exec_cycles = pct_pkg::EXEC_BASE;
    endcase
  end

  assign acc_is_store = (st.access_stage.cls == pct_pkg::CLS_STORE);
  assign access_kind = acc_is_store ? pct_pkg::ACC_WRITE : pct_pkg::ACC_READ;

  pct_access_lut u_fetch_lut (
    .kind   (pct_pkg::ACC_FETCH),
    .rgn    (st.fetch_stage.fsrc),
    .size   (pct_pkg::SZ_WORD),
    .cycles (fetch_cycles)
  );

  pct_access_lut u_access_lut (
    .kind   (access_kind),
    .rgn    (st.access_stage.mrgn),
    .size   (st.access_stage.msize),
    .cycles (access_cycles)
  );

  // Queue hits never wait on the bus
  assign t_rdy[pct_pkg::TIMED_FETCH] = (st.fetch_stage.fsrc == pct_pkg::RGN_QUEUE) || fetch_rdy;
  assign t_rdy[pct_pkg::TIMED_EXEC] = 1'b1;
  assign t_rdy[pct_pkg::TIMED_ACCESS] = mem_rdy;

  assign t_target[pct_pkg::TIMED_FETCH] = fetch_cycles;
  assign t_target[pct_pkg::TIMED_EXEC] = exec_cycles;
  assign t_target[pct_pkg::TIMED_ACCESS] = access_cycles;

  assign t_occ[pct_pkg::TIMED_FETCH] = st.fetch_stage.vld;
  assign t_occ[pct_pkg::TIMED_EXEC] = st.exec_stage.vld;
  assign t_occ[pct_pkg::TIMED_ACCESS] = st.access_stage.vld;

  assign t_leave[pct_pkg::TIMED_FETCH] = fetch_to_dec;
  assign t_leave[pct_pkg::TIMED_EXEC] = ex_leave;
  assign t_leave[pct_pkg::TIMED_ACCESS] = acc_leave;

  for (genvar g = 0; g < pct_pkg::NUM_TIMED; g++) begin : g_timer
    pct_occ_timer #(
      .CNT_W (pct_pkg::CNT_W)
    ) u_timer (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .occupied (t_occ[g]),
      .leave    (t_leave[g]),
      .target   (t_target[g]),
      .ready    (t_rdy[g]),
      .done     (t_done[g])
    );
  end

  // Advance decisions, oldest stage first
  always_comb begin
    ex_needs_access = (st.exec_stage.cls == pct_pkg::CLS_LOAD) ||
                      (st.exec_stage.cls == pct_pkg::CLS_STORE);

    // Write-back drains every cycle, so a load never waits for it
    acc_to_wb = t_done[pct_pkg::TIMED_ACCESS] && !acc_is_store;
    acc_post = t_done[pct_pkg::TIMED_ACCESS] && acc_is_store && wbuf_ready;
    acc_leave = acc_to_wb || acc_post;

    ex_to_acc = t_done[pct_pkg::TIMED_EXEC] && ex_needs_access &&
                (!st.access_stage.vld || acc_leave);
    // Younger work never passes an occupant still held in access
    ex_to_wb = t_done[pct_pkg::TIMED_EXEC] && !ex_needs_access &&
               (!st.access_stage.vld || acc_post);
    ex_leave = ex_to_acc || ex_to_wb;

    dec_to_ex = st.decode_stage.vld && (!st.exec_stage.vld || ex_leave);
    fetch_to_dec = t_done[pct_pkg::TIMED_FETCH] && (!st.decode_stage.vld || dec_to_ex);

    // Next fetch waits until the branch clears execute
    branch_pending = (st.fetch_stage.vld && st.fetch_stage.brn) ||
                     (st.decode_stage.vld && st.decode_stage.brn) ||
                     (st.exec_stage.vld && st.exec_stage.brn);

    in_ready = (!st.fetch_stage.vld || fetch_to_dec) && !branch_pending;
    fetch_take = in_valid && in_ready;

    any_hold = (t_done[pct_pkg::TIMED_FETCH] && !fetch_to_dec) ||
               (st.decode_stage.vld && !dec_to_ex) ||
               (t_done[pct_pkg::TIMED_EXEC] && !ex_leave) ||
               (t_done[pct_pkg::TIMED_ACCESS] && !acc_leave);
  end

  // Next pipeline contents
  always_comb begin
    next_st = st;

    // Write-back lasts exactly one cycle
    next_st.writeback_stage = '0;
    if (acc_to_wb) begin
      next_st.writeback_stage = st.access_stage;
    end else if (ex_to_wb) begin
      next_st.writeback_stage = st.exec_stage;
    end

    // Stores vanish after posting; no write-back slot
    if (acc_leave) begin
      next_st.access_stage.vld = 1'b0;
    end
    if (ex_to_acc) begin
      next_st.access_stage = st.exec_stage;
    end

    if (ex_leave) begin
      next_st.exec_stage.vld = 1'b0;
    end
    if (dec_to_ex) begin
      next_st.exec_stage = st.decode_stage;
    end

    // Decode has no minimum; it holds only until execute can take it
    if (dec_to_ex) begin
      next_st.decode_stage.vld = 1'b0;
    end
    if (fetch_to_dec) begin
      next_st.decode_stage = st.fetch_stage;
    end

    if (fetch_to_dec) begin
      next_st.fetch_stage.vld = 1'b0;
    end
    if (fetch_take) begin
      next_st.fetch_stage.vld = 1'b1;
      next_st.fetch_stage.cls = in_cls;
      next_st.fetch_stage.brn = in_branch;
      next_st.fetch_stage.mrgn = in_mrgn;
      next_st.fetch_stage.msize = in_msize;
      next_st.fetch_stage.fsrc = in_fsrc;
      next_st.fetch_stage.tag = in_tag;
    end

    if (any_hold && (st.stalls != 16'hffff)) begin
      next_st.stalls = st.stalls + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // Bus-facing requests, straight from stage registers
  assign fetch_req = st.fetch_stage.vld && (st.fetch_stage.fsrc != pct_pkg::RGN_QUEUE);
  assign fetch_rgn = st.fetch_stage.fsrc;
  assign fetch_tag = st.fetch_stage.tag;

  assign mem_req = st.access_stage.vld;
  assign mem_we = st.access_stage.vld && acc_is_store;
  assign mem_rgn = st.access_stage.mrgn;
  assign mem_size = st.access_stage.msize;
  assign mem_tag = st.access_stage.tag;

  // Posting is the end of the store; the real write follows in the buffer
  assign wbuf_post = acc_post;

  assign retire = st.writeback_stage.vld;
  assign retire_tag = st.writeback_stage.tag;

  assign stage_busy = {st.writeback_stage.vld, st.access_stage.vld, st.exec_stage.vld,
                       st.decode_stage.vld, st.fetch_stage.vld};
  assign stalled = any_hold;
  assign stall_count = st.stalls;
endmodule
`default_nettype wire

/* pct_tb_model.sv */
// Purpose: Far-side model of fetch bus, data bus and write buffer
// Assumes: Ready levels change just after the falling edge
// Notes:   Slow mode stretches accesses at random
`default_nettype none
package pct_tb_pkg;
  function automatic int fmin(pct_pkg::pct_rgn_t r);
    return r == pct_pkg::RGN_EXTERNAL ? 8 : r == pct_pkg::RGN_PERIPH ? 4 : 1;
  endfunction
  function automatic int amin(logic we, pct_pkg::pct_rgn_t r, pct_pkg::pct_size_t s);
    logic w;
    w = s == pct_pkg::SZ_WORD;
    case (r)
      pct_pkg::RGN_PERIPH:   return w ? 4 : 2;
      pct_pkg::RGN_EXTERNAL: return we ? (w ? 8 : 4) : (w ? 9 : 5);
      default:               return 1;
    endcase
  endfunction
endpackage

module pct_bus_model (
  input  wire logic ref_clk,    // System clock
  input  wire logic slow,       // Stretch accesses
  output logic      fetch_rdy,  // Fetch may finish
  output logic      mem_rdy,    // Access may finish
  output logic      wbuf_ready  // Buffer has room
);
  timeunit 1ns;
  timeprecision 1ps;
  // Late answers test that minimums are not treated as maximums
  always @(negedge ref_clk) begin
    fetch_rdy <= !slow || ($urandom % 3 == 0);
    mem_rdy <= !slow || ($urandom % 3 == 0);
    wbuf_ready <= !slow || ($urandom % 2 == 0);
  end
endmodule
`default_nettype wire

/* pct_pipeline_checker.sv */
// Purpose: Timing relations at the pipeline's ports
// Assumes: Tags in flight are unique
// Notes:   Occupancy counted only in cycles with ce high
`default_nettype none
module pct_pipeline_checker #(
  parameter int TAG_W = pct_pkg::TAG_W
) (
  input wire logic               ref_clk,     // Clock
  input wire logic               rst_n,       // Reset
  input wire logic               ce,          // Enable
  input wire logic               in_ready,    // Accepts
  input wire logic               fetch_req,   // Fetch busy
  input wire pct_pkg::pct_rgn_t  fetch_rgn,   // Fetch region
  input wire logic [TAG_W-1:0]   fetch_tag,   // Fetch tag
  input wire logic               fetch_rdy,   // Fetch ready
  input wire logic               mem_req,     // Access busy
  input wire logic               mem_we,      // Store
  input wire pct_pkg::pct_rgn_t  mem_rgn,     // Access region
  input wire pct_pkg::pct_size_t mem_size,    // Access width
  input wire logic [TAG_W-1:0]   mem_tag,     // Access tag
  input wire logic               mem_rdy,     // Access ready
  input wire logic               wbuf_post,   // Posted
  input wire logic               wbuf_ready,  // Room
  input wire logic               retire,      // Write-back
  input wire logic [TAG_W-1:0]   retire_tag,  // Retired tag
  input wire logic [4:0]         stage_busy,  // Occupancy
  input wire logic               stalled,     // Held
  input wire logic [15:0]        stall_count  // Held cycles
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic             fq;
  logic             mq;
  logic [TAG_W-1:0] ft;
  logic [TAG_W-1:0] mt;
  int               fc;
  int               mc;
  int               fcur;
  int               mcur;
  assign fcur = (fetch_req && (!fq || fetch_tag != ft)) ? 1 : fc + 1;
  assign mcur = (mem_req && (!mq || mem_tag != mt)) ? 1 : mc + 1;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fq <= 1'b0;
      mq <= 1'b0;
    end else if (ce) begin
      fq <= fetch_req;
      mq <= mem_req;
      ft <= fetch_tag;
      mt <= mem_tag;
      fc <= fcur;
      mc <= mcur;
    end
  end
  a_fetch_min_time: assert property (
    fetch_req && ce && fcur < pct_tb_pkg::fmin(fetch_rgn) |=> fetch_req && fetch_tag == $past(fetch_tag))
    else $error("fetch left before its minimum");
  a_mem_min_time: assert property (
    mem_req && ce && mcur < pct_tb_pkg::amin(mem_we, mem_rgn, mem_size) |=> mem_req && $stable(mem_tag))
    else $error("access left before its minimum");
  a_fetch_waits_rdy: assert property (
    fetch_req && ce && !fetch_rdy |=> fetch_req && $stable(fetch_tag))
    else $error("fetch left without ready");
  a_mem_waits_rdy: assert property (
    mem_req && ce && !(mem_rdy && (wbuf_ready || !mem_we)) |=> mem_req && mem_tag == $past(mem_tag))
    else $error("access left without ready");
  a_post_needs_room: assert property (
    wbuf_post && ce |-> mem_req && mem_we && wbuf_ready && mem_rdy)
    else $error("post without a ready store");
  a_load_then_retire: assert property (
    mem_req && !mem_we && ce ##1 (!mem_req || mem_tag != $past(mem_tag)) |-> retire && retire_tag == $past(mem_tag))
    else $error("load did not retire after access");
  a_store_no_retire: assert property (
    mem_req && mem_we && ce ##1 (!mem_req || mem_tag != $past(mem_tag)) |-> !(retire && retire_tag == $past(mem_tag)))
    else $error("store reached write-back");
  a_retire_one_cycle: assert property (
    retire && ce |=> !(retire && retire_tag == $past(retire_tag)))
    else $error("write-back longer than one cycle");
  a_stall_counted: assert property (
    stalled && ce && stall_count != 16'hffff |=> stall_count == $past(stall_count) + 16'h0001)
    else $error("stall cycle not counted");
  a_reset_empty: assert property (
    $rose(rst_n) |-> stage_busy == 5'h00 && !retire && !fetch_req && !mem_req && stall_count == 16'h0000 && in_ready)
    else $error("pipeline not empty after reset");
  c_back_to_back: cover property (retire && ce ##1 retire && ce);
  c_post: cover property (wbuf_post && ce);
  c_stall: cover property (stalled && ce);
  c_ext_word: cover property (mem_req && mem_rgn == pct_pkg::RGN_EXTERNAL && mem_size == pct_pkg::SZ_WORD);
endmodule
`default_nettype wire

/* pipeline_cycle_timing_test.sv */
// Purpose: Self-checking bench for the pipeline timing block
// Assumes: Inputs change on the falling edge
// Notes:   Timed checks run with an empty pipeline and a prompt far side
`default_nettype none
module pipeline_cycle_timing_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    pct_pkg::pct_cls_t  c;
    logic               b;
    pct_pkg::pct_rgn_t  f;
    pct_pkg::pct_rgn_t  m;
    pct_pkg::pct_size_t s;
    logic [7:0]         t;
  } pct_ins_t;
  logic               ref_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               ce = 1'b1;
  logic               in_valid = 1'b0;
  logic               in_branch = 1'b0;
  logic               slow = 1'b0;
  logic               took = 1'b0;
  pct_pkg::pct_cls_t  in_cls = pct_pkg::CLS_OTHER;
  pct_pkg::pct_rgn_t  in_fsrc = pct_pkg::RGN_QUEUE;
  pct_pkg::pct_rgn_t  in_mrgn = pct_pkg::RGN_INTERNAL;
  pct_pkg::pct_size_t in_msize = pct_pkg::SZ_WORD;
  logic [7:0]         in_tag = 8'h00;
  logic               in_ready, fetch_req, fetch_rdy, mem_req, mem_we, mem_rdy, wbuf_post, wbuf_ready;
  logic               retire, stalled;
  pct_pkg::pct_rgn_t  fetch_rgn, mem_rgn;
  pct_pkg::pct_size_t mem_size;
  logic [7:0]         fetch_tag, mem_tag, retire_tag, nt = 8'h00, t;
  logic [4:0]         stage_busy;
  logic [15:0]        stall_count;
  pct_ins_t           iq[$];
  logic [7:0]         rq[$], sq[$];
  int                 acc[256], ret[256], exl[256];
  int                 cyc = 0, num_errors = 0, checks = 0;

  pct_pipeline DUT (.ref_clk, .rst_n, .ce, .in_valid, .in_ready, .in_cls, .in_branch, .in_fsrc, .in_mrgn,
    .in_msize, .in_tag, .fetch_req, .fetch_rgn, .fetch_tag, .fetch_rdy, .mem_req, .mem_we, .mem_rgn, .mem_size,
    .mem_tag, .mem_rdy, .wbuf_post, .wbuf_ready, .retire, .retire_tag, .stage_busy, .stalled, .stall_count);
  pct_bus_model u_bus (.ref_clk, .slow, .fetch_rdy, .mem_rdy, .wbuf_ready);

  initial forever #5 ref_clk = ~ref_clk;

  function automatic int lat(pct_ins_t i);
    int e;
    e = i.c == pct_pkg::CLS_PRODUCT ? 3 : (i.c == pct_pkg::CLS_QUOTIENT || i.c == pct_pkg::CLS_MODULO) ? 37 : 1;
    if (i.c == pct_pkg::CLS_STORE) return pct_tb_pkg::fmin(i.f) + 1 + e + pct_tb_pkg::amin(1'b1, i.m, i.s);
    return pct_tb_pkg::fmin(i.f) + 2 + e + (i.c == pct_pkg::CLS_LOAD ? pct_tb_pkg::amin(1'b0, i.m, i.s) : 0);
  endfunction

  task automatic chk_tag(logic [7:0] got, logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t value got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_int(int got, int exp);
    checks++;
    if (got != exp) begin
      num_errors++;
      $display("[ERR] %0t cycles got %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic put(int c, logic b, int f, int m, int s, logic timed);
    pct_ins_t i;
    i = '{pct_pkg::pct_cls_t'(c), b, pct_pkg::pct_rgn_t'(f), pct_pkg::pct_rgn_t'(m), pct_pkg::pct_size_t'(s), nt};
    exl[nt] = timed ? lat(i) : 0;
    if (i.c == pct_pkg::CLS_STORE) sq.push_back(nt);
    else rq.push_back(nt);
    iq.push_back(i);
    nt++;
  endtask
  task automatic drain();
    while (iq.size() + rq.size() + sq.size() > 0) @(negedge ref_clk);
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic seen(logic [7:0] got, logic [7:0] exp);
    chk_tag(got, exp);
    ret[got] = cyc;
    if (exl[got] > 0) chk_int(cyc - acc[got], exl[got]);
  endtask
  task automatic close_out();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    took <= rst_n && ce && in_valid && in_ready;
    if (rst_n && ce && in_valid && in_ready) acc[in_tag] = cyc;
    if (rst_n && ce && retire === 1'b1) seen(retire_tag, rq.size() > 0 ? rq.pop_front() : 8'hxx);
    if (rst_n && ce && wbuf_post === 1'b1) seen(mem_tag, sq.size() > 0 ? sq.pop_front() : 8'hxx);
    if (cyc > 60000) begin
      num_errors++;
      close_out();
    end
  end
  // Queue head stays on the pins until taken, so refusals lose nothing
  always @(negedge ref_clk) begin
    if (took) void'(iq.pop_front());
    ce <= !slow || ($urandom % 8 != 0);
    in_valid <= iq.size() > 0;
    if (iq.size() > 0) begin
      in_cls <= iq[0].c;
      in_branch <= iq[0].b;
      in_fsrc <= iq[0].f;
      in_mrgn <= iq[0].m;
      in_msize <= iq[0].s;
      in_tag <= iq[0].t;
    end
  end

  initial begin
    void'($urandom(41043));
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk_tag({3'h0, stage_busy}, 8'h00);
    chk_tag({7'h00, in_ready}, 8'h01);
    for (int c = 0; c < 6; c++)
      for (int r = 0; r < 4; r++)
        for (int s = 0; s < 3; s++) begin
          put(c, 1'b0, r, r == 0 ? 1 : r, s, 1'b1);
          drain();
        end
    for (int r = 0; r < 4; r++) begin
      t = nt;
      put(5, 1'b1, r, 1, 2, 1'b1);
      put(5, 1'b0, 0, 1, 2, 1'b1);
      drain();
      chk_int(acc[8'(t + 8'h01)] - acc[t], pct_tb_pkg::fmin(pct_pkg::pct_rgn_t'(r)) + 3);
    end
    for (int c = 2; c < 4; c++) begin
      t = nt;
      put(c, 1'b0, 0, 1, 2, 1'b1);
      put(5, 1'b0, 0, 1, 2, 1'b0);
      drain();
      chk_int(ret[8'(t + 8'h01)] - acc[t], (c == 2 ? 3 : 37) + 4);
    end
    slow = 1'b1;
    repeat (300) put($urandom % 6, $urandom % 4 == 0, $urandom % 4, 1 + $urandom % 3, $urandom % 3, 1'b0);
    drain();
    close_out();
  end
endmodule

bind pct_pipeline pct_pipeline_checker #(.TAG_W(TAG_W)) u_chk (.ref_clk, .rst_n, .ce, .in_ready, .fetch_req,
  .fetch_rgn, .fetch_tag, .fetch_rdy, .mem_req, .mem_we, .mem_rgn, .mem_size, .mem_tag, .mem_rdy, .wbuf_post,
  .wbuf_ready, .retire, .retire_tag, .stage_busy, .stalled, .stall_count);
`default_nettype wire
